// ### hpo_consts.svh
// Offsets, field positions, reset values and timing counts of the hot-plug output unit
`ifndef HPO_CONSTS_SVH
`define HPO_CONSTS_SVH

// Register indexes; the bus byte address is four times the index
`define HPO_IDX_CTL      12'h0C00
`define HPO_IDX_STS      12'h0C01
`define HPO_IDX_IEN      12'h0C02
`define HPO_IDX_QUEUE    12'h0C03
`define HPO_IDX_WMIN     12'h0C04
`define HPO_IDX_WMAX     12'h0C05
`define HPO_IDX_RISE     12'h0C06
`define HPO_IDX_FALL     12'h0C08
`define HPO_IDX_PGEN     12'h0C0A

// Control register fields
`define HPO_CTL_EN       0
`define HPO_CTL_DIR      1
`define HPO_CTL_GEN      2
`define HPO_CTL_LVL      3
`define HPO_CTL_STATE    7

// Status register fields
`define HPO_STS_PULSE    0
`define HPO_STS_FALL     1
`define HPO_STS_RISE     2
`define HPO_STS_QNE      3

// Queue field codes
`define HPO_EV_EMPTY     2'h0
`define HPO_EV_RISE      2'h1
`define HPO_EV_FALL      2'h2
`define HPO_EV_SHORT     2'h3
`define HPO_EV_CLEAR     2'h1

`define HPO_RST_BYTE     8'h00
`define HPO_RST_WORD     16'h0000

// Timing: one step is 50 us; detect windows add a 100 us base
`define HPO_CLK_MHZ      50
`define HPO_STEP_US      50
`define HPO_BASE_US      100
`define HPO_STEP_CYCLES  (`HPO_STEP_US * `HPO_CLK_MHZ)
`define HPO_BASE_STEPS   (`HPO_BASE_US / `HPO_STEP_US)

`endif

// ### hpo_pkg.sv
// Types shared by the hot-plug output unit
package hpo_pkg;

   typedef struct packed {
      logic gen;
      logic lvl;
      logic dir;
      logic en;
   } hpo_ctl_t;

   typedef struct packed {
      logic qne;
      logic rise;
      logic fall;
      logic pulse;
   } hpo_sts_t;

   typedef enum logic {
      PG_IDLE,
      PG_LOW
   } hpo_pg_state_t;

endpackage

// ### hpo_hot_plug.sv
// Hot-plug pin unit: output drive, pulse generation, receiver, status and Avalon-MM registers
`timescale 1ns/1ps
`include "hpo_consts.svh"

module hpo_hot_plug
   import hpo_pkg::*;
#(
   parameter int STEP_CYCLES = `HPO_STEP_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [13:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        hot_plug_pin_i,
   output logic             hot_plug_pin_o,
   output logic             hot_plug_pin_oe_o,
   output logic             unit_summary_interrupt_o
);

   // True once a run of steps has reached the programmed time plus the base
   function automatic logic steps_reached(input logic [16:0] run, input logic [15:0] n);
      logic [17:0] lim;
      lim = {2'b00, n} + 18'(`HPO_BASE_STEPS);
      return {1'b0, run} >= lim;
   endfunction

   hpo_ctl_t      ctl_q;
   hpo_sts_t      sts_q;
   hpo_pg_state_t pg_q;
   logic [3:0]    ien_q;
   logic [7:0]    wmin_q;
   logic [7:0]    wmax_q;
   logic [15:0]   rise_q;
   logic [15:0]   fall_q;
   logic [7:0]    pdur_q;
   logic [7:0]    queue_q;
   logic [1:0]    wptr_q;
   logic          ack_q;
   logic [31:0]   rdata_q;
   logic [31:0]   rdata_d;
   logic          sync1_q;
   logic          sync2_q;
   logic          line_q;
   logic [16:0]   run_q;
   logic [2:0]    ev_q;
   logic [31:0]   step_cnt_q;
   logic [8:0]    pcnt_q;
   logic          pin_q;
   logic          pin_oe_q;
   logic          step;
   logic          rx_on;
   logic          tx_on;
   logic          pulse_start;
   logic          pulse_done;
   logic          pulse_reject;
   logic          line_state;
   logic [11:0]   idx;
   logic          wr_acc;
   logic          rd_acc;
   logic          enq;
   logic [1:0]    ev_code;
   logic [7:0]    wd0;

   // One wait cycle per access so read data can come from a flip-flop
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign avs_readdata_o    = rdata_q;
   assign idx    = avs_address_i[13:2];
   assign wr_acc = avs_write_i & ack_q;
   assign rd_acc = avs_read_i & ack_q;
   assign wd0    = avs_writedata_i[7:0];

   assign tx_on = ctl_q.en & ctl_q.dir;
   assign rx_on = ctl_q.en & ~ctl_q.dir;

   // Output mode reports the pin, held high while our own pulse pulls it low
   always_comb begin
      if (!ctl_q.en) begin
         line_state = 1'b0;
      end else if (ctl_q.dir) begin
         line_state = sync2_q | (pg_q == PG_LOW);
      end else begin
         line_state = line_q;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      end
   end

   // Unmapped indexes, including the holes above 16-bit registers, read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (idx)
         `HPO_IDX_CTL: begin
            rdata_d[`HPO_CTL_EN]    = ctl_q.en;
            rdata_d[`HPO_CTL_DIR]   = ctl_q.dir;
            rdata_d[`HPO_CTL_GEN]   = ctl_q.gen & ctl_q.dir;
            rdata_d[`HPO_CTL_LVL]   = ctl_q.lvl & ctl_q.dir;
            rdata_d[`HPO_CTL_STATE] = line_state;
         end
         `HPO_IDX_STS:   rdata_d[3:0]  = sts_q;
         `HPO_IDX_IEN:   rdata_d[3:0]  = ien_q;
         `HPO_IDX_QUEUE: rdata_d[7:0]  = rx_on ? queue_q : `HPO_RST_BYTE;
         `HPO_IDX_WMIN:  rdata_d[7:0]  = wmin_q;
         `HPO_IDX_WMAX:  rdata_d[7:0]  = wmax_q;
         `HPO_IDX_RISE:  rdata_d[15:0] = rise_q;
         `HPO_IDX_FALL:  rdata_d[15:0] = fall_q;
         `HPO_IDX_PGEN:  rdata_d[7:0]  = pdur_q;
         default:        rdata_d       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_i && !ack_q) begin
         rdata_q <= rdata_d;
      end
   end

   // Plain storage registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ien_q  <= 4'h0;
         wmin_q <= `HPO_RST_BYTE;
         wmax_q <= `HPO_RST_BYTE;
         rise_q <= `HPO_RST_WORD;
         fall_q <= `HPO_RST_WORD;
         pdur_q <= `HPO_RST_BYTE;
      end else if (wr_acc) begin
         if (avs_byteenable_i[0]) begin
            unique case (idx)
               `HPO_IDX_IEN:  ien_q  <= wd0[3:0];
               `HPO_IDX_WMIN: wmin_q <= wd0;
               `HPO_IDX_WMAX: wmax_q <= wd0;
               `HPO_IDX_RISE: rise_q[7:0] <= wd0;
               `HPO_IDX_FALL: fall_q[7:0] <= wd0;
               `HPO_IDX_PGEN: pdur_q <= wd0;
               default: ;
            endcase
         end
         // Upper lane only reaches the two 16-bit registers
         if (avs_byteenable_i[1] && idx == `HPO_IDX_RISE) begin
            rise_q[15:8] <= avs_writedata_i[15:8];
         end
         if (avs_byteenable_i[1] && idx == `HPO_IDX_FALL) begin
            fall_q[15:8] <= avs_writedata_i[15:8];
         end
      end
   end

   // Control register; the pulse request is accepted only with the write that
   // selects output mode and enable
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl_q <= '0;
      end else begin
         if (wr_acc && avs_byteenable_i[0] && idx == `HPO_IDX_CTL) begin
            ctl_q.en  <= wd0[`HPO_CTL_EN];
            ctl_q.dir <= wd0[`HPO_CTL_DIR];
            ctl_q.lvl <= wd0[`HPO_CTL_LVL];
            ctl_q.gen <= wd0[`HPO_CTL_GEN] & wd0[`HPO_CTL_DIR] & wd0[`HPO_CTL_EN];
         end else if (pulse_done || pulse_reject || !tx_on) begin
            ctl_q.gen <= 1'b0;
         end
      end
   end

   // Step divider, restarted at pulse start so the low time is exact
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         step_cnt_q <= 32'h0000_0000;
      end else if (pulse_start || step) begin
         step_cnt_q <= 32'h0000_0000;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
   end
   assign step = (step_cnt_q == 32'(STEP_CYCLES - 1));

   // A request with the level low cannot make a pulse and is dropped
   assign pulse_start  = (pg_q == PG_IDLE) && ctl_q.gen && tx_on && ctl_q.lvl;
   assign pulse_reject = (pg_q == PG_IDLE) && ctl_q.gen && !ctl_q.lvl;
   assign pulse_done   = (pg_q == PG_LOW) && tx_on && (pcnt_q >= {1'b0, pdur_q});

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pg_q   <= PG_IDLE;
         pcnt_q <= 9'h000;
      end else begin
         unique case (pg_q)
            PG_IDLE: begin
               pcnt_q <= 9'h000;
               if (pulse_start) begin
                  pg_q <= PG_LOW;
               end
            end
            PG_LOW: begin
               if (!tx_on || pulse_done) begin
                  pg_q <= PG_IDLE;
               end else if (step) begin
                  pcnt_q <= pcnt_q + 9'h001;
               end
            end
         endcase
      end
   end

   // Pin drive, registered
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_q    <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_oe_q <= tx_on;
         pin_q    <= tx_on & ctl_q.lvl & ~(pulse_start | (pg_q == PG_LOW));
      end
   end
   assign hot_plug_pin_o    = pin_q;
   assign hot_plug_pin_oe_o = pin_oe_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= hot_plug_pin_i;
         sync2_q <= sync1_q;
      end
   end

   // Receiver: logical state starts low and changes only after a debounced run
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_q <= 1'b0;
         run_q  <= 17'h0_0000;
         ev_q   <= 3'b000;
      end else if (!rx_on) begin
         line_q <= 1'b0;
         run_q  <= 17'h0_0000;
         ev_q   <= 3'b000;
      end else begin
         ev_q <= 3'b000;
         if (sync2_q != line_q) begin
            if (step && run_q != 17'h1_FFFF) begin
               run_q <= run_q + 17'h0_0001;
            end
            if (!line_q && steps_reached(run_q, rise_q)) begin
               line_q                <= 1'b1;
               run_q                 <= 17'h0_0000;
               ev_q[`HPO_STS_RISE]   <= 1'b1;
            end else if (line_q && steps_reached(run_q, fall_q)) begin
               line_q                <= 1'b0;
               run_q                 <= 17'h0_0000;
               ev_q[`HPO_STS_FALL]   <= 1'b1;
            end
         end else begin
            // Back high after a low run: short pulse if inside the window
            if (line_q && steps_reached(run_q, {8'h00, wmin_q}) &&
                !steps_reached(run_q, {8'h00, wmax_q} + 16'h0001)) begin
               ev_q[`HPO_STS_PULSE] <= 1'b1;
            end
            run_q <= 17'h0_0000;
         end
      end
   end

   // Event queue: at most one event per cycle; full slots drop new events
   assign ev_code = ev_q[`HPO_STS_RISE] ? `HPO_EV_RISE :
                    ev_q[`HPO_STS_FALL] ? `HPO_EV_FALL : `HPO_EV_SHORT;
   assign enq = (|ev_q) && (queue_q[{wptr_q, 1'b0} +: 2] == `HPO_EV_EMPTY);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         queue_q <= `HPO_RST_BYTE;
         wptr_q  <= 2'b00;
      end else if (!rx_on) begin
         queue_q <= `HPO_RST_BYTE;
         wptr_q  <= 2'b00;
      end else begin
         if (wr_acc && avs_byteenable_i[0] && idx == `HPO_IDX_QUEUE) begin
            for (int i = 0; i < 4; i++) begin
               if (wd0[2*i +: 2] == `HPO_EV_CLEAR) begin
                  queue_q[2*i +: 2] <= `HPO_EV_EMPTY;
               end
            end
         end
         if (enq) begin
            queue_q[{wptr_q, 1'b0} +: 2] <= ev_code;
            wptr_q                       <= wptr_q + 2'b01;
         end
      end
   end

   // Status: set wins over write-one-to-clear; disable wipes everything
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sts_q <= '0;
      end else if (!ctl_q.en) begin
         sts_q <= '0;
      end else begin
         if (wr_acc && avs_byteenable_i[0] && idx == `HPO_IDX_STS) begin
            sts_q.rise  <= (sts_q.rise  & ~wd0[`HPO_STS_RISE])  | ev_q[`HPO_STS_RISE];
            sts_q.fall  <= (sts_q.fall  & ~wd0[`HPO_STS_FALL])  | ev_q[`HPO_STS_FALL];
            sts_q.pulse <= (sts_q.pulse & ~wd0[`HPO_STS_PULSE]) | ev_q[`HPO_STS_PULSE]
                           | pulse_done;
         end else begin
            sts_q.rise  <= sts_q.rise  | ev_q[`HPO_STS_RISE];
            sts_q.fall  <= sts_q.fall  | ev_q[`HPO_STS_FALL];
            sts_q.pulse <= sts_q.pulse | ev_q[`HPO_STS_PULSE] | pulse_done;
         end
         if (enq) begin
            sts_q.qne <= 1'b1;
         end else if (rd_acc && idx == `HPO_IDX_QUEUE) begin
            sts_q.qne <= 1'b0;
         end
      end
   end

   assign unit_summary_interrupt_o = |(sts_q & ien_q);

   pin_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_on |=> hot_plug_pin_oe_o && (hot_plug_pin_o == ($past(ctl_q.lvl) && !$past(pg_q == PG_LOW)
                                                      && !$past(pulse_start))))
      else $error("pin not driven with output level");

   pulse_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pulse_start |=> (pg_q == PG_LOW) ##1 !hot_plug_pin_o)
      else $error("pulse did not pull pin low");

   gen_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pulse_done && !wr_acc) |=> !ctl_q.gen && (pg_q == PG_IDLE))
      else $error("request bit not cleared after pulse");

   pulse_sts_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pulse_done |=> sts_q.pulse)
      else $error("pulse status not set on completion");

   summary_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(sts_q.pulse) && ien_q[`HPO_STS_PULSE] |-> unit_summary_interrupt_o)
      else $error("summary interrupt missing");

   state_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (avs_read_i && !avs_waitrequest_o && idx == `HPO_IDX_CTL && !$past(ctl_q.en))
      |-> !avs_readdata_o[`HPO_CTL_STATE])
      else $error("state bit not zero while disabled");

   level_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (avs_read_i && !avs_waitrequest_o && idx == `HPO_IDX_CTL && !$past(ctl_q.dir))
      |-> !avs_readdata_o[`HPO_CTL_LVL])
      else $error("level bit not zero in input mode");

   sts_wipe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctl_q.en |=> (sts_q == '0))
      else $error("status not cleared on disable");

   set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctl_q.en && ev_q[`HPO_STS_RISE]) |=> sts_q.rise)
      else $error("event lost against clear");

   queue_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_acc && idx == `HPO_IDX_QUEUE && !enq && ctl_q.en) |=> !sts_q.qne)
      else $error("queue flag not cleared by read");

endmodule

// ### hpo_display_model.sv
// Display-side model of the hot-plug line: sink drive, pull-down and low-time meter
`timescale 1ns/1ps
module hpo_display_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        pin_i,
   input  wire logic        pin_oe_i,
   input  wire logic        drive_en_i,
   input  wire logic        drive_lvl_i,
   output logic             line_o,
   output logic      [15:0] low_width_o
);
   logic [15:0] run_q;

   // Line released by both unit and sink falls to the pull-down, never keeps its last level
   assign line_o = pin_oe_i ? pin_i : (drive_en_i ? drive_lvl_i : 1'b0);

   // Length of the last low run while the unit drives the line
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_q       <= 16'h0000;
         low_width_o <= 16'h0000;
      end else if (pin_oe_i && !line_o) begin
         run_q <= run_q + 16'h0001;
      end else begin
         if (run_q != 16'h0000) begin
            low_width_o <= run_q;
         end
         run_q <= 16'h0000;
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the hot-plug output unit
`timescale 1ns/1ps
`include "hpo_consts.svh"
module testbench;
   localparam int STEP  = 4;
   localparam int PULSE = 3 * STEP;

   typedef struct packed {
      logic [11:0] idx;
      logic [31:0] wd;
      logic [31:0] exp;
   } hpo_row_t;

   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic [13:0] avs_address = 14'h0000;
   logic        avs_read    = 1'b0;
   logic        avs_write   = 1'b0;
   logic [31:0] avs_wdata   = 32'h0000_0000;
   logic        drv_en      = 1'b0;
   logic        drv_lvl     = 1'b0;
   logic [31:0] avs_rdata;
   logic        waitreq;
   logic        pin_o;
   logic        pin_oe;
   logic        irq;
   logic        line;
   logic [15:0] low_width;
   logic [31:0] rdata;
   int          fail_count  = 0;
   int          n_tests     = 0;
   hpo_row_t    rows [7]    = '{
      '{`HPO_IDX_IEN,  32'h0000_00F5, 32'h0000_0005},
      '{`HPO_IDX_WMIN, 32'h0000_0012, 32'h0000_0012},
      '{`HPO_IDX_WMAX, 32'h0000_0034, 32'h0000_0034},
      '{`HPO_IDX_RISE, 32'h0000_1234, 32'h0000_1234},
      '{`HPO_IDX_FALL, 32'h0000_ABCD, 32'h0000_ABCD},
      '{`HPO_IDX_PGEN, 32'h0000_0003, 32'h0000_0003},
      '{12'h0C07,      32'h0000_0055, 32'h0000_0000}
   };

   always #10 clk_i = ~clk_i;

   hpo_hot_plug #(.STEP_CYCLES(STEP)) dut (
      .clk_i                    (clk_i),
      .rst_i                    (rst_i),
      .avs_address_i            (avs_address),
      .avs_read_i               (avs_read),
      .avs_write_i              (avs_write),
      .avs_writedata_i          (avs_wdata),
      .avs_byteenable_i         (4'b0011),
      .avs_readdata_o           (avs_rdata),
      .avs_waitrequest_o        (waitreq),
      .hot_plug_pin_i           (line),
      .hot_plug_pin_o           (pin_o),
      .hot_plug_pin_oe_o        (pin_oe),
      .unit_summary_interrupt_o (irq)
   );

   hpo_display_model model (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .pin_i       (pin_o),
      .pin_oe_i    (pin_oe),
      .drive_en_i  (drv_en),
      .drive_lvl_i (drv_lvl),
      .line_o      (line),
      .low_width_o (low_width)
   );

   task automatic tally_and_finish(input logic timed_out);
      if (timed_out) fail_count++;
      $display("Checks run %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      avs_address <= {idx, 2'b00};
      avs_write   <= wr;
      avs_read    <= ~wr;
      avs_wdata   <= wd;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_i);
         if (waitreq === 1'b0) break;
      end
      rdata = avs_rdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (k == 50) tally_and_finish(1'b1);
   endtask

   task automatic reg_rd(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      check(rdata, exp);
   endtask

   task automatic poll(input logic [11:0] idx, input int b, input logic v);
      int k;
      for (k = 0; k < 300; k++) begin
         bus(1'b0, idx, 32'h0000_0000);
         if (rdata[b] === v) break;
      end
      if (k == 300) tally_and_finish(1'b1);
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      reg_rd(`HPO_IDX_CTL, 32'h0000_0000);
      reg_rd(`HPO_IDX_STS, 32'h0000_0000);
      check({30'h0000_0000, pin_oe, irq}, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, rows[i].idx, rows[i].wd);
         reg_rd(rows[i].idx, rows[i].exp);
      end
      // Reserved index past 0C0A is only read; the 0C07 hole is written in the table above
      reg_rd(12'h0C0B, 32'h0000_0000);
      // Static output levels
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_000B);
      repeat (5) @(posedge clk_i);
      check({30'h0000_0000, pin_oe, pin_o}, 32'h0000_0003);
      reg_rd(`HPO_IDX_CTL, 32'h0000_008B);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_0003);
      repeat (5) @(posedge clk_i);
      check({30'h0000_0000, pin_oe, pin_o}, 32'h0000_0002);
      reg_rd(`HPO_IDX_CTL, 32'h0000_0003);
      // Generated pulse, three steps long
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_000B);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_000F);
      reg_rd(`HPO_IDX_CTL, 32'h0000_008F);
      poll(`HPO_IDX_CTL, `HPO_CTL_GEN, 1'b0);
      reg_rd(`HPO_IDX_STS, 32'h0000_0001);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      check({31'h0000_0000, (low_width >= PULSE && low_width <= PULSE + 3)}, 32'h0000_0001);
      check({31'h0000_0000, pin_o}, 32'h0000_0001);
      bus(1'b1, `HPO_IDX_IEN, 32'h0000_0000);
      @(posedge clk_i);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      bus(1'b1, `HPO_IDX_IEN, 32'h0000_0001);
      @(posedge clk_i);
      check({31'h0000_0000, irq}, 32'h0000_0001);
      bus(1'b1, `HPO_IDX_STS, 32'h0000_0001);
      reg_rd(`HPO_IDX_STS, 32'h0000_0000);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      // Request with a low level gives no pulse
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_0003);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_0007);
      reg_rd(`HPO_IDX_CTL, 32'h0000_0003);
      reg_rd(`HPO_IDX_STS, 32'h0000_0000);
      // Disable wipes a pending status
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_000B);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_000F);
      poll(`HPO_IDX_CTL, `HPO_CTL_GEN, 1'b0);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_0000);
      reg_rd(`HPO_IDX_STS, 32'h0000_0000);
      reg_rd(`HPO_IDX_CTL, 32'h0000_0000);
      check({30'h0000_0000, pin_oe, irq}, 32'h0000_0000);
      // Input mode: level bit hidden, sink raises the line
      bus(1'b1, `HPO_IDX_RISE, 32'h0000_0000);
      bus(1'b1, `HPO_IDX_CTL, 32'h0000_0009);
      drv_en <= 1'b1;
      bus(1'b0, `HPO_IDX_CTL, 32'h0000_0000);
      check(rdata & 32'h0000_007F, 32'h0000_0001);
      check({31'h0000_0000, pin_oe}, 32'h0000_0000);
      repeat (20) @(posedge clk_i);
      drv_lvl <= 1'b1;
      poll(`HPO_IDX_STS, `HPO_STS_RISE, 1'b1);
      check({31'h0000_0000, rdata[`HPO_STS_QNE]}, 32'h0000_0001);
      bus(1'b0, `HPO_IDX_QUEUE, 32'h0000_0000);
      check({30'h0000_0000, rdata[1:0]}, {30'h0000_0000, `HPO_EV_RISE});
      bus(1'b0, `HPO_IDX_STS, 32'h0000_0000);
      check({31'h0000_0000, rdata[`HPO_STS_QNE]}, 32'h0000_0000);
      bus(1'b1, `HPO_IDX_STS, 32'h0000_0004);
      bus(1'b0, `HPO_IDX_STS, 32'h0000_0000);
      check({31'h0000_0000, rdata[`HPO_STS_RISE]}, 32'h0000_0000);
      // Sink low for about 30 steps: inside the short-pulse window, far below fall time
      drv_lvl <= 1'b0;
      repeat (60) @(posedge clk_i);
      reg_rd(`HPO_IDX_CTL, 32'h0000_0081);
      repeat (57) @(posedge clk_i);
      drv_lvl <= 1'b1;
      poll(`HPO_IDX_STS, `HPO_STS_PULSE, 1'b1);
      check(rdata & 32'h0000_0007, 32'h0000_0001);
      bus(1'b0, `HPO_IDX_QUEUE, 32'h0000_0000);
      check({30'h0000_0000, rdata[3:2]}, {30'h0000_0000, `HPO_EV_SHORT});
      // Reset in mid-run
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      reg_rd(`HPO_IDX_CTL, 32'h0000_0000);
      check({31'h0000_0000, pin_oe}, 32'h0000_0000);
      tally_and_finish(1'b0);
   end
endmodule
